// ===== core/pwm_front.sv
// Control front end of a four-channel 8-bit pulse-width modulator
module pwm_front (
  input  wire logic       core_clk,          // Bus clock, 100 MHz
  input  wire logic       nrst,              // Async reset, active low
  input  wire logic [2:0] addr,              // Register offset
  input  wire logic [7:0] wdata,             // Write data
  input  wire logic       wr,                // Write strobe
  input  wire logic       rd,                // Read strobe
  output logic      [7:0] rdata,             // Read data, cycle after rd
  input  wire logic       scaled_clock_a,    // Scaled clock A tick
  input  wire logic       scaled_clock_b,    // Scaled clock B tick
  input  wire logic [3:0] period_start,      // Period start per channel
  input  wire logic [3:0] duty_reached,      // Duty count reached
  output logic            clock_a_tick,      // Prescaled clock A tick
  output logic            clock_b_tick,      // Prescaled clock B tick
  output logic      [3:0] channel_tick,      // Selected source tick
  output logic      [3:0] channel_active,    // Enable synchronised
  output logic            prescaler_running, // Prescaler counting
  output logic            join_upper_pair,   // Channels 2 and 3 joined
  output logic            join_lower_pair,   // Channels 0 and 1 joined
  output logic      [3:0] pwm_out,           // Waveform pins
  output logic      [3:0] pwm_oe             // Pin output enables
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Register hit for one offset, shared by the write decodes
  function automatic logic reg_hit(
    input logic [2:0] a,
    input logic [2:0] off
  );
    return a == off;
  endfunction : reg_hit

  // Scaled tick when the select bit is set, else the prescaled one
  function automatic logic pick_source(
    input logic sel,
    input logic scaled,
    input logic plain
  );
    return sel ? scaled : plain;
  endfunction : pick_source

  function automatic logic is_run(
    input pwm_front_pkg::ch_state_e s
  );
    return s == pwm_front_pkg::CH_RUN;
  endfunction : is_run

  // Polarity gives the start level, the duty phase flips it
  function automatic logic pin_level(
    input logic pol,
    input logic ph
  );
    return pol ^ ph;
  endfunction : pin_level

  //////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] channel_enable_reg;
  logic [7:0] polarity_reg;
  logic [7:0] clock_select_reg;
  logic [7:0] prescale_select_reg;
  logic [7:0] control_reg;

  logic       wr_enable;
  logic       wr_polarity;
  logic       wr_clk_sel;
  logic       wr_prescale;
  logic       wr_control;

  assign wr_enable   = wr && reg_hit(addr, pwm_front_pkg::OFF_ENABLE);
  assign wr_polarity = wr && reg_hit(addr, pwm_front_pkg::OFF_POLARITY);
  assign wr_clk_sel  = wr && reg_hit(addr, pwm_front_pkg::OFF_CLK_SEL);
  assign wr_prescale = wr && reg_hit(addr, pwm_front_pkg::OFF_PRESCALE);
  assign wr_control  = wr && reg_hit(addr, pwm_front_pkg::OFF_CONTROL);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      channel_enable_reg <= pwm_front_pkg::RST_ENABLE;
    end else if (wr_enable) begin
      channel_enable_reg <= wdata & pwm_front_pkg::MASK_CH;
    end
  end

  // Taken straight away; the waveform logic tolerates a mid-period change
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      polarity_reg <= pwm_front_pkg::RST_POLARITY;
    end else if (wr_polarity) begin
      polarity_reg <= wdata & pwm_front_pkg::MASK_CH;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clock_select_reg <= pwm_front_pkg::RST_CLK_SEL;
    end else if (wr_clk_sel) begin
      clock_select_reg <= wdata & pwm_front_pkg::MASK_CH;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_select_reg <= pwm_front_pkg::RST_PRESCALE;
    end else if (wr_prescale) begin
      prescale_select_reg <= wdata & pwm_front_pkg::MASK_PRESCALE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      control_reg <= pwm_front_pkg::RST_CONTROL;
    end else if (wr_control) begin
      control_reg <= wdata & pwm_front_pkg::MASK_CONTROL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe, else zero

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = pwm_front_pkg::READ_ZERO;
    if (rd) begin
      unique case (addr)
        pwm_front_pkg::OFF_ENABLE: begin
          next_rdata = channel_enable_reg;
        end
        pwm_front_pkg::OFF_POLARITY: begin
          next_rdata = polarity_reg;
        end
        pwm_front_pkg::OFF_CLK_SEL: begin
          next_rdata = clock_select_reg;
        end
        pwm_front_pkg::OFF_PRESCALE: begin
          next_rdata = prescale_select_reg;
        end
        pwm_front_pkg::OFF_CONTROL: begin
          next_rdata = control_reg;
        end
        default: begin
          next_rdata = pwm_front_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= pwm_front_pkg::READ_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pair joining and effective enables

  logic [3:0] eff_en;
  logic       join_hi;
  logic       join_lo;

  assign join_hi = control_reg[pwm_front_pkg::JOIN_HI_BIT];
  assign join_lo = control_reg[pwm_front_pkg::JOIN_LO_BIT];

  // A joined pair runs from the high-order channel's own bits
  assign eff_en[0] = channel_enable_reg[0] && !join_lo;
  assign eff_en[1] = channel_enable_reg[1];
  assign eff_en[2] = channel_enable_reg[2] && !join_hi;
  assign eff_en[3] = channel_enable_reg[3];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      join_upper_pair <= 1'b0;
      join_lower_pair <= 1'b0;
    end else begin
      join_upper_pair <= join_hi;
      join_lower_pair <= join_lo;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler: gated by the raw enable bits, not the effective ones

  logic run_pre;
  logic tick_a;
  logic tick_b;

  assign run_pre = |channel_enable_reg[pwm_front_pkg::CH_MSB:
                                       pwm_front_pkg::CH_LSB];

  pwm_prescaler u_prescaler (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (run_pre),
    .div_a    (prescale_select_reg[pwm_front_pkg::DIV_A_MSB:
                                   pwm_front_pkg::DIV_A_LSB]),
    .div_b    (prescale_select_reg[pwm_front_pkg::DIV_B_MSB:
                                   pwm_front_pkg::DIV_B_LSB]),
    .tick_a   (tick_a),
    .tick_b   (tick_b)
  );

  assign clock_a_tick = tick_a;
  assign clock_b_tick = tick_b;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescaler_running <= 1'b0;
    end else begin
      prescaler_running <= run_pre;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel clock source select

  logic [3:0] src_tick;

  always_comb begin
    src_tick[0] = pick_source(clock_select_reg[0], scaled_clock_a,
                              tick_a);
    src_tick[1] = pick_source(clock_select_reg[1], scaled_clock_a,
                              tick_a);
    src_tick[2] = pick_source(clock_select_reg[2], scaled_clock_b,
                              tick_b);
    src_tick[3] = pick_source(clock_select_reg[3], scaled_clock_b,
                              tick_b);
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel enable synchroniser and waveform

  pwm_front_pkg::ch_state_e ch_state [pwm_front_pkg::NCH];
  pwm_front_pkg::ch_state_e next_ch_state [pwm_front_pkg::NCH];
  logic [3:0]               phase;

  for (genvar i = 0; i < pwm_front_pkg::NCH; i++) begin : g_ch

    // Arm on enable, start only on the source's next tick
    always_comb begin
      next_ch_state[i] = ch_state[i];
      unique case (ch_state[i])
        pwm_front_pkg::CH_OFF: begin
          if (eff_en[i]) begin
            next_ch_state[i] = pwm_front_pkg::CH_ARMED;
          end
        end
        pwm_front_pkg::CH_ARMED: begin
          if (!eff_en[i]) begin
            next_ch_state[i] = pwm_front_pkg::CH_OFF;
          end else if (src_tick[i]) begin
            next_ch_state[i] = pwm_front_pkg::CH_RUN;
          end
        end
        pwm_front_pkg::CH_RUN: begin
          if (!eff_en[i]) begin
            next_ch_state[i] = pwm_front_pkg::CH_OFF;
          end
        end
        default: begin
          next_ch_state[i] = pwm_front_pkg::CH_OFF;
        end
      endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        ch_state[i] <= pwm_front_pkg::CH_OFF;
      end else begin
        ch_state[i] <= next_ch_state[i];
      end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        channel_active[i] <= 1'b0;
        channel_tick[i]   <= 1'b0;
      end else begin
        channel_active[i] <= is_run(next_ch_state[i]);
        channel_tick[i]   <= src_tick[i];
      end
    end

    // Phase 0 before the duty match, 1 after; duty wins a same-cycle clash.
    // The counters are not aligned at arm time, so the first period may
    // be short or long.
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        phase[i] <= 1'b0;
      end else if (!is_run(ch_state[i])) begin
        phase[i] <= 1'b0;
      end else if (duty_reached[i]) begin
        phase[i] <= 1'b1;
      end else if (period_start[i]) begin
        phase[i] <= 1'b0;
      end
    end

    // Pin level is polarity xor phase, so a polarity write acts at once
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        pwm_out[i] <= 1'b0;
        pwm_oe[i]  <= 1'b0;
      end else begin
        pwm_oe[i] <= eff_en[i];
        if (is_run(next_ch_state[i]) && is_run(ch_state[i])) begin
          pwm_out[i] <= pin_level(polarity_reg[i], phase[i]);
        end else if (is_run(next_ch_state[i])) begin
          pwm_out[i] <= pin_level(polarity_reg[i], 1'b0);
        end else begin
          pwm_out[i] <= 1'b0;
        end
      end
    end

  end : g_ch

endmodule : pwm_front

// ===== core/pwm_front_pkg.sv
// Constants, types and shared functions of the PWM control front end
package pwm_front_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NCH    = 4;
  localparam int PRE_W  = 7;

  // Register offsets
  localparam logic [2:0] OFF_ENABLE   = 3'h0;
  localparam logic [2:0] OFF_POLARITY = 3'h1;
  localparam logic [2:0] OFF_CLK_SEL  = 3'h2;
  localparam logic [2:0] OFF_PRESCALE = 3'h3;
  localparam logic [2:0] OFF_CONTROL  = 3'h5;

  // Field positions
  localparam int CH_LSB      = 0;
  localparam int CH_MSB      = 3;
  localparam int DIV_A_LSB   = 0;
  localparam int DIV_A_MSB   = 2;
  localparam int DIV_B_LSB   = 4;
  localparam int DIV_B_MSB   = 6;
  localparam int JOIN_LO_BIT = 4;
  localparam int JOIN_HI_BIT = 5;

  // Writable bits of each register; the rest reads as zero
  localparam logic [7:0] MASK_CH       = 8'h0F;
  localparam logic [7:0] MASK_PRESCALE = 8'h77;
  localparam logic [7:0] MASK_CONTROL  = 8'h30;

  // Reset values
  localparam logic [7:0] RST_ENABLE   = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CLK_SEL  = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

  // Channel enable synchroniser states, Gray along off-armed-run
  typedef enum logic [1:0] {
    CH_OFF   = 2'h0,
    CH_ARMED = 2'h1,
    CH_RUN   = 2'h3
  } ch_state_e;

  // Tick of bus clock divided by 2**sel, taken from a free counter
  function automatic logic prescale_tick(
    input logic [PRE_W-1:0] cnt,
    input logic [2:0]       sel
  );
    logic [PRE_W-1:0] m;
    m = 7'h00;
    for (int b = 0; b < PRE_W; b++) begin
      if (b < int'(sel)) begin
        m[b] = 1'b1;
      end
    end
    return (cnt & m) == m;
  endfunction : prescale_tick

endpackage : pwm_front_pkg

// ===== core/pwm_prescaler.sv
// Power-of-two prescaler that makes clock A and clock B ticks
module pwm_prescaler (
  input  wire logic       core_clk, // Bus clock
  input  wire logic       nrst,     // Asynchronous reset, active low
  input  wire logic       run,      // Counter runs while high
  input  wire logic [2:0] div_a,    // Clock A divider exponent
  input  wire logic [2:0] div_b,    // Clock B divider exponent
  output logic            tick_a,   // One-cycle clock A tick
  output logic            tick_b    // One-cycle clock B tick
);

  logic [pwm_front_pkg::PRE_W-1:0] cnt;

  // Counter is cleared while stopped so ticks restart from phase zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= pwm_front_pkg::PRE_ZERO;
    end else if (run) begin
      cnt <= cnt + 7'h01;
    end else begin
      cnt <= pwm_front_pkg::PRE_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end else begin
      tick_a <= run && pwm_front_pkg::prescale_tick(cnt, div_a);
      tick_b <= run && pwm_front_pkg::prescale_tick(cnt, div_b);
    end
  end

endmodule : pwm_prescaler

// ===== verif/pwm_front_chk.sv
// Assertion checker for the PWM control front end
module pwm_front_chk (
  input wire logic       core_clk,          // Bus clock
  input wire logic       nrst,              // Async reset, active low
  input wire logic       rd,                // Read strobe
  input wire logic [7:0] rdata,             // Read data
  input wire logic       scaled_clock_a,    // Scaled clock A tick
  input wire logic       scaled_clock_b,    // Scaled clock B tick
  input wire logic       clock_a_tick,      // Clock A tick
  input wire logic       clock_b_tick,      // Clock B tick
  input wire logic [3:0] channel_tick,      // Selected source tick
  input wire logic [3:0] channel_active,    // Channel running
  input wire logic       prescaler_running, // Prescaler counting
  input wire logic       join_upper_pair,   // Channels 2 and 3 joined
  input wire logic       join_lower_pair,   // Channels 0 and 1 joined
  input wire logic [3:0] pwm_out,           // Waveform pins
  input wire logic [3:0] pwm_oe             // Pin output enables
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read cycle");
  property p_join_lo;
    join_lower_pair && $past(join_lower_pair) |-> !pwm_oe[0];
  endproperty
  a_join_lo: assert property (p_join_lo)
    else $error("channel 0 pin enabled while lower pair joined");
  property p_join_hi;
    join_upper_pair && $past(join_upper_pair) |-> !pwm_oe[2];
  endproperty
  a_join_hi: assert property (p_join_hi)
    else $error("channel 2 pin enabled while upper pair joined");
  property p_out_idle;
    !channel_active[1] && !$past(channel_active[1]) |-> !pwm_out[1];
  endproperty
  a_out_idle: assert property (p_out_idle)
    else $error("channel 1 waveform while not running");
  property p_pre_stop;
    !prescaler_running && !$past(prescaler_running)
      |-> !clock_a_tick && !clock_b_tick;
  endproperty
  a_pre_stop: assert property (p_pre_stop)
    else $error("prescaler ticks while stopped");
  property p_src_a;
    channel_tick[0] |-> $past(clock_a_tick) || $past(scaled_clock_a);
  endproperty
  a_src_a: assert property (p_src_a)
    else $error("channel 0 tick without clock A source");
  property p_src_b;
    channel_tick[3] |-> $past(clock_b_tick) || $past(scaled_clock_b);
  endproperty
  a_src_b: assert property (p_src_b)
    else $error("channel 3 tick without clock B source");
  property p_act_rise;
    $rose(channel_active[1]) |-> $past(clock_a_tick) || $past(scaled_clock_a);
  endproperty
  a_act_rise: assert property (p_act_rise)
    else $error("channel 1 started without a source tick");
  c_act: cover property ($rose(channel_active[1]));
  c_join: cover property (join_upper_pair && join_lower_pair);
  c_read: cover property (rd);
endmodule : pwm_front_chk

bind pwm_front pwm_front_chk u_chk (.core_clk(core_clk), .nrst(nrst),
  .rd(rd), .rdata(rdata), .scaled_clock_a(scaled_clock_a),
  .scaled_clock_b(scaled_clock_b), .clock_a_tick(clock_a_tick),
  .clock_b_tick(clock_b_tick), .channel_tick(channel_tick),
  .channel_active(channel_active), .prescaler_running(prescaler_running),
  .join_upper_pair(join_upper_pair), .join_lower_pair(join_lower_pair),
  .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// ===== verif/testbench.sv
// Self-checking testbench of the PWM control front end
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  errors++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, nrst = 0, wr = 0, rd = 0, sca = 0, scb = 0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [3:0] pst = 4'h0, dty = 4'h0, ctick, act, pout, poe;
  logic       ta, tb, run, jhi, jlo;
  int         errors = 0, n_tests = 0;
  pwm_front u_pwm_front (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scaled_clock_a(sca),
    .scaled_clock_b(scb), .period_start(pst), .duty_reached(dty),
    .clock_a_tick(ta), .clock_b_tick(tb), .channel_tick(ctick),
    .channel_active(act), .prescaler_running(run), .join_upper_pair(jhi),
    .join_lower_pair(jlo), .pwm_out(pout), .pwm_oe(poe));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // Gap between the next two ticks; the first may follow a change irregularly
  task automatic tick_gap(input bit b, output int n);
    int k;
    k = 0;
    do begin cyc(1); k++; end while ((b ? tb : ta) !== 1'b1 && k < 300);
    n = 0;
    do begin cyc(1); n++; end while ((b ? tb : ta) !== 1'b1 && n < 300);
  endtask : tick_gap
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] d, m [8];
    m = '{pwm_front_pkg::MASK_CH, pwm_front_pkg::MASK_CH,
          pwm_front_pkg::MASK_CH, pwm_front_pkg::MASK_PRESCALE, 8'h00,
          pwm_front_pkg::MASK_CONTROL, 8'h00, 8'h00};
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a), d);
      `CHK("reset value", 8'h00, d)
      wr_reg(3'(a), 8'hFF);
      rd_reg(3'(a), d);
      `CHK("masked readback", m[a], d)
      wr_reg(3'(a), 8'h00);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_wave;
    int k;
    wr_reg(pwm_front_pkg::OFF_POLARITY, 8'h02);
    wr_reg(pwm_front_pkg::OFF_ENABLE, 8'h02);
    k = 0;
    do begin cyc(1); k++; end while (act[1] !== 1'b1 && k < 20);
    `CHK("ch1 started", 1'b1, act[1])
    `CHK("ch1 pin enabled", 1'b1, poe[1])
    `CHK("ch1 starts high", 1'b1, pout[1])
    @(posedge core_clk) dty <= 4'h2;
    @(posedge core_clk) dty <= 4'h0;
    cyc(3);
    `CHK("ch1 low after duty", 1'b0, pout[1])
    @(posedge core_clk) pst <= 4'h2;
    @(posedge core_clk) pst <= 4'h0;
    cyc(3);
    `CHK("ch1 high at period", 1'b1, pout[1])
    wr_reg(pwm_front_pkg::OFF_POLARITY, 8'h00);
    cyc(3);
    `CHK("ch1 low start", 1'b0, pout[1])
    @(posedge core_clk) dty <= 4'h2;
    @(posedge core_clk) dty <= 4'h0;
    cyc(3);
    `CHK("ch1 high after duty", 1'b1, pout[1])
    wr_reg(pwm_front_pkg::OFF_ENABLE, 8'h00);
    cyc(3);
    `CHK("ch1 stopped", 4'h0, {act[1], pout[1], poe[1], run})
    k = 0;
    repeat (20) begin cyc(1); k += int'(ta | tb); end
    `CHK("no ticks while stopped", 0, k)
    $display("test wave done");
  endtask : t_wave
  task automatic t_join;
    wr_reg(pwm_front_pkg::OFF_CONTROL, 8'h30);
    wr_reg(pwm_front_pkg::OFF_ENABLE, 8'h0F);
    cyc(3);
    `CHK("join flags", 2'b11, {jhi, jlo})
    `CHK("both joined enables", 4'hA, poe)
    wr_reg(pwm_front_pkg::OFF_CONTROL, 8'h10);
    cyc(3);
    `CHK("lower joined enables", 4'hE, poe)
    wr_reg(pwm_front_pkg::OFF_CONTROL, 8'h20);
    cyc(3);
    `CHK("upper joined enables", 4'hB, poe)
    wr_reg(pwm_front_pkg::OFF_CONTROL, 8'h00);
    $display("test join done");
  endtask : t_join
  task automatic t_clocks;
    int n;
    for (int e = 0; e < 8; e++) begin
      wr_reg(pwm_front_pkg::OFF_PRESCALE, 8'((7 - e) << 4 | e));
      tick_gap(1'b0, n);
      `CHK("clock A gap", 1 << e, n)
      tick_gap(1'b1, n);
      `CHK("clock B gap", 1 << (7 - e), n)
    end
    wr_reg(pwm_front_pkg::OFF_PRESCALE, 8'h77);
    wr_reg(pwm_front_pkg::OFF_CLK_SEL, 8'h0F);
    cyc(2);
    @(posedge core_clk) sca <= 1'b1;
    @(posedge core_clk) sca <= 1'b0;
    #1;
    `CHK("scaled A ticks", 4'h3, ctick)
    @(posedge core_clk) scb <= 1'b1;
    @(posedge core_clk) scb <= 1'b0;
    #1;
    `CHK("scaled B ticks", 4'hC, ctick)
    wr_reg(pwm_front_pkg::OFF_ENABLE, 8'h00);
    $display("test clocks done");
  endtask : t_clocks
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_wave();
    t_join();
    wr_reg(pwm_front_pkg::OFF_ENABLE, 8'h01);
    t_clocks();
    finish_test();
  end
endmodule : testbench
